// ### logic/afe_setup_control_regs.sv
// setup register bank of the three-channel front end with its control outputs
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - identification register is read-only, returns a fixed 8-bit code, writes ignored.
// - setup bit 0 global enable; clear powers everything down, set makes it active.
// - with enable set, separate power-down bits still switch individual blocks off.
// - setup bit 1 picks sampling: 0 plain, 1 double sampling; resets to 1.
// - bit 2 gives single-channel mode on the selected input, others powered down.
// - bit 3 gives two-channel mode when bit 2 is clear; both bits clear gives three-channel mode.
// - offset field 0x makes zero differential input give code 511.
// - offset field 10 makes zero input give full-scale code 1023.
// - offset field 11 makes zero input give code 0.
// - divider field 00 none, 01 by two, 10 by three; 11 must not be written.
// - polarity inversion clear keeps output sense, set reverses it.
module afe_setup_control_regs
   import afe_setup_pkg::*;
#(
   parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary value
   parameter int unsigned CODE_W = 10
)(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [CODE_W-1:0] amp_diff,
   input wire logic amp_valid,
   output power_ctl_t power_ctl,
   output logic sampling_double,
   output channel_mode_t channel_mode,
   output logic analog_clk_en,
   output logic [CODE_W-1:0] out_code,
   output logic out_valid
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] chan_onehot(input logic [1:0] sel);
      logic [2:0] hot;
      hot = 3'h0;
      case (sel)
         2'h1: hot = 3'h2;
         2'h2: hot = 3'h4;
         default: hot = 3'h1;
      endcase
      return hot;
   endfunction : chan_onehot

   function automatic channel_mode_t mode_of(input setup_one_t s);
      channel_mode_t m;
      m = MODE_THREE;
      if (s.single_channel_select) begin
         m = MODE_SINGLE;
      end else if (s.dual_channel_select) begin
         m = MODE_TWO;
      end
      return m;
   endfunction : mode_of

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   setup_one_t setup_one_r;
   setup_one_t setup_one_nxt;
   logic [7:0] polarity_ctl_r;
   logic [7:0] channel_ctl_r;
   logic [7:0] block_powerdown_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   power_ctl_t power_ctl_r;
   logic sampling_double_r;
   channel_mode_t channel_mode_r;
   logic analog_clk_en_r;
   logic [1:0] div_count_r;
   logic [1:0] div_count_nxt;
   logic [CODE_W-1:0] out_code_r;
   logic [CODE_W-1:0] out_code_nxt;
   logic out_valid_r;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire logic [9:0] index = paddr[11:2];
   wire logic setup_phase = psel && !penable;
   wire logic write_now = psel && penable && pready_r && pwrite && pstrb[0];
   wire logic hit_id = (index == IDX_PART_NUMBER_HIGH);
   wire logic hit_setup = (index == IDX_SETUP_ONE);
   wire logic hit_pol = (index == IDX_POLARITY_CTL);
   wire logic hit_chan = (index == IDX_CHANNEL_CTL);
   wire logic hit_pd = (index == IDX_BLOCK_POWERDOWN);
   wire logic hit_stat = (index == IDX_STATUS);
   wire logic mapped = hit_id || hit_setup || hit_pol || hit_chan || hit_pd || hit_stat;
   wire logic wr_setup = write_now && hit_setup;
   wire logic wr_pol = write_now && hit_pol;
   wire logic wr_chan = write_now && hit_chan;
   wire logic wr_pd = write_now && hit_pd;
   wire setup_one_t wr_value = setup_one_t'(pwdata[7:0]);

   // the reserved divider code never reaches the divider
   wire logic [1:0] div_keep = (wr_value.analog_clock_divider == DIV_INVALID) ?
      setup_one_r.analog_clock_divider : wr_value.analog_clock_divider;

   always_comb begin
      setup_one_nxt = setup_one_r;
      if (wr_setup) begin
         setup_one_nxt = wr_value;
         setup_one_nxt.analog_clock_divider = div_keep;
      end
   end

   wire logic [7:0] status_byte = {analog_clk_en_r, power_ctl_r.chip_active,
      power_ctl_r.adc_power, power_ctl_r.channel_power, channel_mode_r};

   // the identification code is a constant on the read path only
   wire logic [7:0] read_byte =
      hit_id ? PART_CODE :
      hit_setup ? setup_one_r :
      hit_pol ? polarity_ctl_r :
      hit_chan ? channel_ctl_r :
      hit_pd ? block_powerdown_r :
      hit_stat ? status_byte : 8'h00;

   // ------------------------------------------------------------
   // bus slave: zero wait states, data prepared in the setup cycle
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup_phase;
         pslverr_r <= setup_phase && !mapped;
         prdata_r <= setup_phase ? {24'h00_0000, read_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         setup_one_r <= setup_one_t'(SETUP_ONE_RESET);
         polarity_ctl_r <= POLARITY_CTL_RESET;
         channel_ctl_r <= CHANNEL_CTL_RESET;
         block_powerdown_r <= BLOCK_POWERDOWN_RESET;
      end else begin
         setup_one_r <= setup_one_nxt;
         if (wr_pol) begin
            polarity_ctl_r <= {7'h00, pwdata[INVERT_BIT]};
         end
         if (wr_chan) begin
            channel_ctl_r <= {6'h00, pwdata[CHAN_LSB+1:CHAN_LSB]};
         end
         if (wr_pd) begin
            block_powerdown_r <= {4'h0, pwdata[3:0]};
         end
      end
   end

   // ------------------------------------------------------------
   // channel mode and power control
   // ------------------------------------------------------------
   wire logic enabled = setup_one_r.global_enable;
   wire channel_mode_t mode_now = mode_of(setup_one_r);
   wire logic [1:0] chan_sel = channel_ctl_r[CHAN_LSB+1:CHAN_LSB];
   wire logic [2:0] mode_chans =
      (mode_now == MODE_SINGLE) ? chan_onehot(chan_sel) :
      (mode_now == MODE_TWO) ? 3'h3 : 3'h7;
   wire logic [2:0] chan_pd = block_powerdown_r[2:0];
   wire logic adc_pd = block_powerdown_r[3];
   logic [2:0] chan_on;

   generate
      for (genvar c = 0; c < 3; c++) begin : g_chan
         assign chan_on[c] = enabled && mode_chans[c] && !chan_pd[c];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         power_ctl_r <= '0;
         sampling_double_r <= 1'b0;
         channel_mode_r <= MODE_THREE;
      end else begin
         power_ctl_r.chip_active <= enabled;
         power_ctl_r.adc_power <= enabled && !adc_pd;
         power_ctl_r.channel_power <= chan_on;
         sampling_double_r <= setup_one_r.double_sampling_select;
         channel_mode_r <= mode_now;
      end
   end

   // ------------------------------------------------------------
   // analogue clock divider
   // ------------------------------------------------------------
   wire logic [1:0] div_sel = setup_one_r.analog_clock_divider;
   wire logic div_last =
      (div_sel == DIV_NONE) ||
      ((div_sel == DIV_TWO) && (div_count_r >= DIV_TWO_LAST)) ||
      ((div_sel == DIV_THREE) && (div_count_r >= DIV_THREE_LAST));

   always_comb begin
      div_count_nxt = div_count_r + 2'h1;
      if (div_last || !enabled) begin
         div_count_nxt = 2'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         div_count_r <= 2'h0;
         analog_clk_en_r <= 1'b0;
      end else begin
         div_count_r <= div_count_nxt;
         analog_clk_en_r <= enabled && div_last;
      end
   end

   // ------------------------------------------------------------
   // output coding: zero-input bias, saturation, polarity
   // ------------------------------------------------------------
   wire logic [1:0] offset_sel = setup_one_r.amp_output_offset_sel;
   wire logic [CODE_W-1:0] bias =
      (offset_sel == OFFSET_FULL_POS) ? CODE_FULL_POS[CODE_W-1:0] :
      (offset_sel == OFFSET_FULL_NEG) ? CODE_FULL_NEG[CODE_W-1:0] :
      CODE_MID[CODE_W-1:0];
   wire logic signed [CODE_W+1:0] sum =
      $signed({2'b00, bias}) + {{2{amp_diff[CODE_W-1]}}, amp_diff};
   wire logic [CODE_W-1:0] code_max = {CODE_W{1'b1}};
   wire logic [CODE_W-1:0] clamped =
      sum[CODE_W+1] ? {CODE_W{1'b0}} :
      sum[CODE_W] ? code_max : sum[CODE_W-1:0];
   wire logic invert = polarity_ctl_r[INVERT_BIT];

   always_comb begin
      out_code_nxt = clamped;
      if (invert) begin
         out_code_nxt = ~clamped;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         out_code_r <= {CODE_W{1'b0}};
         out_valid_r <= 1'b0;
      end else begin
         out_valid_r <= amp_valid && enabled;
         if (amp_valid && enabled) begin
            out_code_r <= out_code_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign power_ctl = power_ctl_r;
   assign sampling_double = sampling_double_r;
   assign channel_mode = channel_mode_r;
   assign analog_clk_en = analog_clk_en_r;
   assign out_code = out_code_r;
   assign out_valid = out_valid_r;

endmodule : afe_setup_control_regs

`default_nettype wire

// ### logic/afe_setup_pkg.sv
// constants, field layouts and types shared by the setup register bank
package afe_setup_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam int unsigned INDEX_W = 10;
   localparam logic [9:0] IDX_PART_NUMBER_HIGH = 10'h000;
   localparam logic [9:0] IDX_SETUP_ONE = 10'h001;
   localparam logic [9:0] IDX_POLARITY_CTL = 10'h002;
   localparam logic [9:0] IDX_CHANNEL_CTL = 10'h003;
   localparam logic [9:0] IDX_BLOCK_POWERDOWN = 10'h004;
   localparam logic [9:0] IDX_STATUS = 10'h005;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned INVERT_BIT = 0;
   localparam int unsigned CHAN_LSB = 0;
   localparam logic [7:0] SETUP_ONE_RESET = 8'h03;
   localparam logic [7:0] POLARITY_CTL_RESET = 8'h00;
   localparam logic [7:0] CHANNEL_CTL_RESET = 8'h00;
   localparam logic [7:0] BLOCK_POWERDOWN_RESET = 8'h00;

   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   localparam logic [1:0] DIV_NONE = 2'h0;
   localparam logic [1:0] DIV_TWO = 2'h1;
   localparam logic [1:0] DIV_THREE = 2'h2;
   localparam logic [1:0] DIV_INVALID = 2'h3;
   localparam logic [1:0] DIV_TWO_LAST = 2'h1;
   localparam logic [1:0] DIV_THREE_LAST = 2'h2;
   localparam logic [1:0] OFFSET_FULL_POS = 2'h2;
   localparam logic [1:0] OFFSET_FULL_NEG = 2'h3;
   localparam logic [9:0] CODE_MID = 10'h1FF;
   localparam logic [9:0] CODE_FULL_POS = 10'h3FF;
   localparam logic [9:0] CODE_FULL_NEG = 10'h000;

   typedef enum logic [1:0] {MODE_THREE, MODE_TWO, MODE_SINGLE} channel_mode_t;

   typedef struct packed {
      logic [1:0] analog_clock_divider;
      logic [1:0] amp_output_offset_sel;
      logic dual_channel_select;
      logic single_channel_select;
      logic double_sampling_select;
      logic global_enable;
   } setup_one_t;

   typedef struct packed {
      logic chip_active;
      logic adc_power;
      logic [2:0] channel_power;
   } power_ctl_t;

endpackage : afe_setup_pkg

// ### verification/afe_setup_control_regs_sva.sv
// port-level assertions for the setup register bank
`timescale 1ns/1ns
`default_nettype none
module afe_setup_control_regs_sva
   import afe_setup_pkg::*;
#(
   parameter logic [7:0] PART_CODE = 8'h5A,
   parameter int unsigned CODE_W = 10
)(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic signed [CODE_W-1:0] amp_diff,
   input wire logic amp_valid,
   input wire power_ctl_t power_ctl,
   input wire logic sampling_double,
   input wire channel_mode_t channel_mode,
   input wire logic analog_clk_en,
   input wire logic [CODE_W-1:0] out_code,
   input wire logic out_valid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire logic [9:0] idx;
   wire logic setup_wr;
   assign idx = paddr[11:2];
   assign setup_wr = psel && penable && pwrite && pstrb[0] && idx == IDX_SETUP_ONE;
   // a sample is taken while the enable is set, seen one cycle later on chip_active
   sequence sample_taken;
      amp_valid ##1 power_ctl.chip_active;
   endsequence
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no ready after setup cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held past access cycle");
   a_err_unmapped: assert property (psel && penable && idx > 10'h005
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_id_read: assert property (psel && penable && !pwrite && idx == IDX_PART_NUMBER_HIGH
      |-> prdata == {24'h000000, PART_CODE})
      else $error("identification code wrong");
   a_sample_out: assert property (sample_taken |-> out_valid)
      else $error("enabled sample gave no output");
   a_no_stray_out: assert property (out_valid |-> $past(amp_valid) && power_ctl.chip_active)
      else $error("output without enabled sample");
   a_power_off: assert property (setup_wr && !pwdata[0] |=> ##1 power_ctl == '0)
      else $error("power not removed by enable clear");
   a_cds_follow: assert property (setup_wr && pwdata[0]
      |=> ##1 sampling_double == $past(pwdata[1], 2))
      else $error("sampling method not applied");
   a_mode_single: assert property (setup_wr && pwdata[0] && pwdata[2]
      |=> ##1 channel_mode == MODE_SINGLE && $onehot0(power_ctl.channel_power))
      else $error("single channel mode wrong");
   a_mode_two: assert property (setup_wr && pwdata[0] && pwdata[3:2] == 2'b10
      |=> ##1 channel_mode == MODE_TWO)
      else $error("two channel mode wrong");
   a_mode_three: assert property (setup_wr && pwdata[0] && pwdata[3:2] == 2'b00
      |=> ##1 channel_mode == MODE_THREE)
      else $error("three channel mode wrong");
endmodule : afe_setup_control_regs_sva
`default_nettype wire

// ### verification/tb_afe_setup_control_regs.sv
// self-checking bench for the setup register bank
`timescale 1ns/1ns
`default_nettype none
module tb_afe_setup_control_regs
   import afe_setup_pkg::*;
;
   localparam logic [7:0] ID_CODE = 8'h3C; // arbitrary value
   logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic amp_valid = 1'b0, pready, pslverr, sampling_double, analog_clk_en, out_valid, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic signed [9:0] amp_diff = 10'sh000;
   logic [9:0] out_code;
   logic [7:0] v, setup_q;
   power_ctl_t power_ctl;
   channel_mode_t channel_mode;
   integer seed = 24, n_errors = 0, compares = 0, cnt;
   always #10 core_clk = ~core_clk;
   afe_setup_control_regs #(.PART_CODE(ID_CODE), .CODE_W(10)) u_afe_setup_control_regs (
      .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .amp_diff(amp_diff), .amp_valid(amp_valid), .power_ctl(power_ctl),
      .sampling_double(sampling_double), .channel_mode(channel_mode),
      .analog_clk_en(analog_clk_en), .out_code(out_code), .out_valid(out_valid));
   // ----------------------------------------
   // tasks and expectations
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task final_report;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for ready
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // write setup with random upper bits, then wait for the derived outputs
   task wr_setup(input logic [7:0] d);
      apb(1'b1, 12'h004, ($random(seed) & 32'hFFFFFF00) | {24'h000000, d}, 4'hF);
      setup_q = (d[7:6] == 2'b11) ? {setup_q[7:6], d[5:0]} : d;
      @(posedge core_clk);
      #1;
   endtask : wr_setup
   task sample(input logic signed [9:0] d);
      @(posedge core_clk);
      amp_valid <= 1'b1;
      amp_diff <= d;
      @(posedge core_clk);
      amp_valid <= 1'b0;
      #1;
      check(out_valid, 1'b1);
   endtask : sample
   function logic [9:0] exp_code(input logic [1:0] off, input logic inv,
      input logic signed [9:0] d);
      integer x;
      x = (off[1] ? (off[0] ? 0 : 1023) : 511) + d;
      if (x < 0) x = 0;
      if (x > 1023) x = 1023;
      return inv ? ~x[9:0] : x[9:0];
   endfunction : exp_code
   function logic [4:0] exp_mode_pwr(input logic [7:0] s);
      return s[2] ? {MODE_SINGLE, 3'b001} : (s[3] ? {MODE_TWO, 3'b011} : {MODE_THREE, 3'b111});
   endfunction : exp_mode_pwr
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      setup_q = SETUP_ONE_RESET;
      apb(1'b1, 12'h000, 32'h000000FF, 4'hF);
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      check(rd, {24'h000000, ID_CODE});
      apb(1'b0, 12'h004, 32'h0, 4'hF);
      check(rd, 32'h00000003);
      apb(1'b0, 12'h100, 32'h0, 4'hF);
      check({err, rd[30:0]}, 32'h80000000);
      for (int i = 0; i < 12; i++) begin
         v = 8'($random(seed)) | 8'h01;
         if (i < 4) v[7:6] = 2'(i);
         if (v[2]) v[3] = 1'b0;
         wr_setup(v);
         check({channel_mode, power_ctl.channel_power}, exp_mode_pwr(setup_q));
         check(sampling_double, setup_q[1]);
         apb(1'b0, 12'h004, 32'h0, 4'hF);
         check(rd, {24'h000000, setup_q});
      end
      for (int dv = 0; dv < 3; dv++) begin
         wr_setup({2'(dv), 6'h03});
         repeat (4) @(posedge core_clk);
         cnt = 0;
         repeat (12) begin
            @(posedge core_clk);
            cnt = cnt + analog_clk_en;
         end
         check(cnt, 12 / (dv + 1));
      end
      for (int k = 0; k < 8; k++) begin
         wr_setup({2'b00, k[1:0], 4'h3});
         apb(1'b1, 12'h008, {31'h0, k[2]}, 4'hF);
         sample(10'sh000);
         check(out_code, exp_code(k[1:0], k[2], 10'sh000));
         if (k == 6) begin
            check(out_code, 32'h0000_0000);
         end
         sample(10'($random(seed)));
         check(out_code, exp_code(k[1:0], k[2], amp_diff));
      end
      apb(1'b1, 12'h010, 32'h00000001, 4'hF);
      @(posedge core_clk);
      #1;
      check(power_ctl, {1'b1, 1'b1, 3'b110});
      apb(1'b1, 12'h00C, 32'h00000002, 4'hF);
      wr_setup(8'h07);
      check(power_ctl.channel_power, 3'b100);
      apb(1'b1, 12'h004, 32'h0, 4'h0);
      @(posedge core_clk);
      #1;
      check(power_ctl.chip_active, 1'b1);
      wr_setup(8'h02);
      check(power_ctl, 5'h00);
      @(posedge core_clk);
      amp_valid <= 1'b1;
      @(posedge core_clk);
      amp_valid <= 1'b0;
      @(posedge core_clk);
      #1;
      check(out_valid, 1'b0);
      final_report;
   end
   initial begin
      #200000;
      n_errors = n_errors + 1;
      final_report;
   end
endmodule : tb_afe_setup_control_regs
bind afe_setup_control_regs afe_setup_control_regs_sva #(.PART_CODE(PART_CODE), .CODE_W(CODE_W))
   u_afe_setup_control_regs_sva (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .amp_diff(amp_diff),
   .amp_valid(amp_valid), .power_ctl(power_ctl), .sampling_double(sampling_double),
   .channel_mode(channel_mode), .analog_clk_en(analog_clk_en), .out_code(out_code),
   .out_valid(out_valid));
`default_nettype wire
